// [rtl/ccd_pkg.sv]
/*
  Package of the calibration coefficient field decoder: nonvolatile field
  positions, decoded value widths, decode constants and the decoded struct.
  Assumes the nonvolatile store presents bits 99 down to 15 as one flat vector.
*/
`default_nettype none
package ccd_pkg;
  // ----------------------------------------------------------------
  // nonvolatile field positions
  // ----------------------------------------------------------------
  localparam int NV_LO = 15;
  localparam int NV_HI = 99;
  localparam int GAIN_B_LSB = 15;
  localparam int GAIN_B_SCALE = 29;
  localparam int OFFS_B_LSB = 30;
  localparam int GAIN_T_LSB = 44;
  localparam int OFFS_T_LSB = 52;
  localparam int TREF_LSB = 60;
  localparam int TCG_LSB = 68;
  localparam int TCO_LSB = 76;
  localparam int TCCFG_LSB = 84;
  localparam int SOT_LSB = 88;
  localparam int PAMP_LSB = 96;
  localparam int SOTSEL_LSB = 98;
  // ----------------------------------------------------------------
  // tempco_config bits and target / gain codes
  // ----------------------------------------------------------------
  localparam int CFG_TCO_NEG = 0;
  localparam int CFG_TCO_X8 = 1;
  localparam int CFG_TCG_NEG = 2;
  localparam int CFG_POL_INV = 3;
  localparam int SOT_SIGN = 7;
  localparam logic [1:0] SEL_BRIDGE = 2'h0;
  localparam logic [1:0] SEL_GAIN_TC = 2'h1;
  localparam logic [1:0] SEL_OFFS_TC = 2'h2;
  localparam logic [1:0] SEL_BAD = 2'h3;
  localparam logic [5:0] PAMP_G6 = 6'h06;
  localparam logic [5:0] PAMP_G24 = 6'h18;
  localparam logic [5:0] PAMP_G12 = 6'h0c;
  localparam logic [5:0] PAMP_G48 = 6'h30;
  localparam int X8_SHIFT = 3;
  localparam int TEMP_RES_BITS = 2;
  // ----------------------------------------------------------------
  // decoded coefficient set
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [16:0] bridge_gain;          // unsigned, 11 fraction bits, 0..64
    logic signed [13:0] bridge_offset; // two's complement
    logic [7:0] temp_gain;             // unsigned, 7 fraction bits
    logic signed [7:0] temp_offset;    // two's complement
    logic [7:0] temp_reference_raw;
    logic signed [8:0] gain_tempco;    // signed gain tempco
    logic signed [11:0] offset_tempco; // signed, x8 applied when config bit 1 set
    logic signed [10:0] second_order;  // signed, x8 applied when on offset tempco and config bit 1 set
    logic [1:0] second_order_target_select;
    logic second_order_on_bridge;
    logic second_order_on_gain_tempco;
    logic second_order_on_offset_tempco;
    logic bridge_polarity_invert;
    logic [5:0] preamp_gain;
  } ccd_coeff_t;
  typedef enum logic [1:0] {
    ST_WAIT = 2'b00,
    ST_RUN = 2'b01
  } ccd_state_t;
endpackage : ccd_pkg
`default_nettype wire

// [rtl/ccd_decoder.sv]
/*
  Calibration coefficient field decoder: holds the coefficient fields of the
  nonvolatile store in working registers and presents decoded values and
  interpreted raw samples to the correction arithmetic.
  Assumes the store controller and the sampling front end share i_ref_clk.
*/
`default_nettype none
// Overview of operation
// - bridge gain from bits 29:15; top bit multiplies lower 14 bits by eight.
// - lower gain bits weigh four at bit 13 down to two^-11 at bit 0.
// - bridge offset from bits 43:30 as signed 14-bit two's complement.
// - temperature gain coefficient taken from bits 51:44.
// - temperature offset coefficient taken from bits 59:52.
// - raw temperature reference taken from bits 67:60.
// - gain tempco magnitude from bits 75:68, negative when config bit 2 set.
// - offset tempco magnitude from bits 83:76, negative when config bit 0 set.
// - tempco config from bits 87:84; bit 3 inverts bridge polarity.
// - config bit 1 scales offset tempco, and second order term on it, by eight.
// - bits 95:88 are sign-magnitude second order term, bit 7 sign.
// - bits 99:98 pick second order target; code 11 is prohibited.
// - bits 97:96 pick preamp gain 6, 24, 12 or 48.
// - raw bridge sample is unsigned 0..16383, one count resolution.
// - raw temperature sample is unsigned 0..16383, four count resolution.
module ccd_decoder
  import ccd_pkg::*;
(
  input wire logic i_ref_clk,                     // 125 MHz internal clock
  input wire logic i_rst_b,                       // async reset, active low
  input wire logic [NV_HI:NV_LO] i_nvm_bits,      // nonvolatile bits 99:15
  input wire logic i_nvm_ready,                   // store contents valid
  input wire logic i_nvm_update,                  // pulse: store rewritten
  input wire logic [13:0] i_bridge_raw_sample,    // raw bridge conversion
  input wire logic [13:0] i_temp_raw_sample,      // raw temperature conversion
  output ccd_coeff_t o_coeff,                     // decoded coefficients
  output logic o_coeff_valid,                     // coefficients loaded
  output logic o_sot_prohibited,                  // target select holds 11
  output logic [13:0] o_bridge_sample,            // interpreted bridge sample
  output logic [13:0] o_temp_sample               // interpreted temperature sample
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // sign-magnitude to two's complement
  function automatic logic signed [11:0] sm_to_tc(input logic [10:0] mag, input logic neg);
    logic signed [11:0] v;
    v = $signed({1'b0, mag});
    sm_to_tc = neg ? -v : v;
  endfunction : sm_to_tc

  ccd_state_t state_reg;
  logic load_now;
  logic [3:0] cfg;
  logic [1:0] sel;
  logic [7:0] second_order_coefficient;
  logic [13:0] gmant;
  logic [10:0] tco_mag;
  logic [10:0] sot_mag;
  logic [5:0] pamp;
  logic signed [11:0] tcg_tc;
  logic signed [11:0] tco_tc;
  logic signed [11:0] sot_tc;

  // field slices of the store vector
  assign cfg = i_nvm_bits[TCCFG_LSB +: 4];
  assign sel = i_nvm_bits[SOTSEL_LSB +: 2];
  assign second_order_coefficient = i_nvm_bits[SOT_LSB +: 8];
  assign gmant = i_nvm_bits[GAIN_B_LSB +: 14];
  assign tco_mag = cfg[CFG_TCO_X8] ? {i_nvm_bits[TCO_LSB +: 8], 3'h0}
                                   : {3'h0, i_nvm_bits[TCO_LSB +: 8]};
  assign sot_mag = (cfg[CFG_TCO_X8] && sel == SEL_OFFS_TC) ? {1'b0, second_order_coefficient[6:0], 3'h0}
                                                           : {4'h0, second_order_coefficient[6:0]};

  // signed forms of the sign-magnitude fields, cut to their register widths at the load
  assign tcg_tc = sm_to_tc({3'h0, i_nvm_bits[TCG_LSB +: 8]}, cfg[CFG_TCG_NEG]);
  assign tco_tc = sm_to_tc(tco_mag, cfg[CFG_TCO_NEG]);
  assign sot_tc = sm_to_tc(sot_mag, second_order_coefficient[SOT_SIGN]);

  // preamp gain code decode
  always_comb begin
    case (i_nvm_bits[PAMP_LSB +: 2])
      2'h0: pamp = PAMP_G6;
      2'h1: pamp = PAMP_G24;
      2'h2: pamp = PAMP_G12;
      2'h3: pamp = PAMP_G48;
      default: pamp = PAMP_G24;
    endcase
  end

  // ----------------------------------------------------------------
  // load sequencing
  // ----------------------------------------------------------------
  assign load_now = (state_reg == ST_WAIT) ? i_nvm_ready : i_nvm_update;

  // wait for the store after reset, then follow rewrites
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= ST_WAIT;
    end else begin
      case (state_reg)
        ST_WAIT: if (i_nvm_ready) state_reg <= ST_RUN;
        ST_RUN: state_reg <= ST_RUN;
        default: state_reg <= ST_WAIT;
      endcase
    end
  end

  // valid flag: low until the first load
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_coeff_valid <= 1'b0;
    end else if (load_now) begin
      o_coeff_valid <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // working registers with decoded fields
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_coeff <= '0;
      o_sot_prohibited <= 1'b0;
    end else if (load_now) begin
      o_coeff.bridge_gain <= i_nvm_bits[GAIN_B_SCALE] ? {gmant, 3'h0} : {3'h0, gmant};
      o_coeff.bridge_offset <= $signed(i_nvm_bits[OFFS_B_LSB +: 14]);
      o_coeff.temp_gain <= i_nvm_bits[GAIN_T_LSB +: 8];
      o_coeff.temp_offset <= $signed(i_nvm_bits[OFFS_T_LSB +: 8]);
      o_coeff.temp_reference_raw <= i_nvm_bits[TREF_LSB +: 8];
      o_coeff.gain_tempco <= tcg_tc[8:0];
      o_coeff.offset_tempco <= tco_tc;
      o_coeff.second_order <= sot_tc[10:0];
      o_coeff.second_order_target_select <= sel;
      o_coeff.second_order_on_bridge <= (sel == SEL_BRIDGE);
      o_coeff.second_order_on_gain_tempco <= (sel == SEL_GAIN_TC);
      o_coeff.second_order_on_offset_tempco <= (sel == SEL_OFFS_TC);
      o_coeff.bridge_polarity_invert <= cfg[CFG_POL_INV];
      o_coeff.preamp_gain <= pamp;
      o_sot_prohibited <= (sel == SEL_BAD);
    end
  end

  // ----------------------------------------------------------------
  // raw sample interpretation
  // ----------------------------------------------------------------
  // bridge: unsigned count, mirrored when polarity is inverted
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_bridge_sample <= '0;
    end else begin
      o_bridge_sample <= o_coeff.bridge_polarity_invert ? ~i_bridge_raw_sample
                                                        : i_bridge_raw_sample;
    end
  end

  // temperature: unsigned, low bits below the four count step cleared
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_temp_sample <= '0;
    end else begin
      o_temp_sample <= {i_temp_raw_sample[13:TEMP_RES_BITS], {TEMP_RES_BITS{1'b0}}};
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_load;
    load_now;
  endsequence

  property p_gain_scale;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      s_load |=> o_coeff.bridge_gain == ($past(i_nvm_bits[GAIN_B_SCALE])
        ? {$past(i_nvm_bits[28:15]), 3'h0} : {3'h0, $past(i_nvm_bits[28:15])});
  endproperty
  a_gain_scale: assert property (p_gain_scale) else $error("bridge gain decode wrong");

  property p_offset_b;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      s_load |=> o_coeff.bridge_offset == $signed($past(i_nvm_bits[43:30]));
  endproperty
  a_offset_b: assert property (p_offset_b) else $error("bridge offset decode wrong");

  property p_temp_fields;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      s_load |=> o_coeff.temp_gain == $past(i_nvm_bits[51:44])
        && o_coeff.temp_offset == $signed($past(i_nvm_bits[59:52]))
        && o_coeff.temp_reference_raw == $past(i_nvm_bits[67:60]);
  endproperty
  a_temp_fields: assert property (p_temp_fields) else $error("temperature fields wrong");

  property p_tcg_sign;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      s_load ##1 o_coeff.gain_tempco != 9'sh0 |-> (o_coeff.gain_tempco < 0) == $past(i_nvm_bits[86]);
  endproperty
  a_tcg_sign: assert property (p_tcg_sign) else $error("gain tempco sign wrong");

  property p_tco_scale;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      s_load ##0 (i_nvm_bits[85] && !i_nvm_bits[84]) |=> o_coeff.offset_tempco[2:0] == 3'h0
        && o_coeff.offset_tempco[10:3] == $past(i_nvm_bits[83:76]);
  endproperty
  a_tco_scale: assert property (p_tco_scale) else $error("offset tempco scaling wrong");

  property p_sot_sign;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      s_load ##0 (i_nvm_bits[95] && i_nvm_bits[94:88] != 7'h0) |=> o_coeff.second_order < 0;
  endproperty
  a_sot_sign: assert property (p_sot_sign) else $error("second order sign wrong");

  property p_prohibited;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      s_load |=> o_sot_prohibited == ($past(i_nvm_bits[99:98]) == SEL_BAD)
        && !(o_coeff.second_order_on_bridge && o_coeff.second_order_on_offset_tempco);
  endproperty
  a_prohibited: assert property (p_prohibited) else $error("target select decode wrong");

  property p_pamp;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      s_load ##0 (i_nvm_bits[97:96] == 2'h3) |=> o_coeff.preamp_gain == PAMP_G48;
  endproperty
  a_pamp: assert property (p_pamp) else $error("preamp gain decode wrong");

  property p_temp_res;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      1'b1 |=> o_temp_sample[1:0] == 2'h0 && o_temp_sample[13:2] == $past(i_temp_raw_sample[13:2]);
  endproperty
  a_temp_res: assert property (p_temp_res) else $error("temperature sample wrong");

  property p_valid_hold;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      !o_coeff_valid && !i_nvm_ready |=> !o_coeff_valid;
  endproperty
  a_valid_hold: assert property (p_valid_hold) else $error("valid before load");

  property p_tco_sign;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      s_load ##0 (i_nvm_bits[83:76] != 8'h0) |=> (o_coeff.offset_tempco < 0) == $past(i_nvm_bits[84]);
  endproperty
  a_tco_sign: assert property (p_tco_sign) else $error("offset tempco sign wrong");

  property p_tco_plain;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      s_load ##0 (!i_nvm_bits[85] && !i_nvm_bits[84]) |=> o_coeff.offset_tempco == {4'h0, $past(i_nvm_bits[83:76])};
  endproperty
  a_tco_plain: assert property (p_tco_plain) else $error("offset tempco unscaled wrong");

  property p_sot_x8;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      s_load ##0 (i_nvm_bits[85] && i_nvm_bits[99:98] == SEL_OFFS_TC && !i_nvm_bits[95])
        |=> o_coeff.second_order == {1'b0, $past(i_nvm_bits[94:88]), 3'h0};
  endproperty
  a_sot_x8: assert property (p_sot_x8) else $error("second order scaling wrong");

  property p_sot_pos;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      s_load ##0 (!i_nvm_bits[95] && i_nvm_bits[99:98] != SEL_OFFS_TC) |=> o_coeff.second_order == {4'h0, $past(i_nvm_bits[94:88])};
  endproperty
  a_sot_pos: assert property (p_sot_pos) else $error("second order magnitude wrong");

  property p_sot_neg;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      s_load ##0 (i_nvm_bits[95] && i_nvm_bits[99:98] != SEL_OFFS_TC)
        |=> o_coeff.second_order == -$signed({4'h0, $past(i_nvm_bits[94:88])});
  endproperty
  a_sot_neg: assert property (p_sot_neg) else $error("second order negative wrong");

  property p_tcg_mag;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      s_load ##0 !i_nvm_bits[86] |=> o_coeff.gain_tempco == {1'b0, $past(i_nvm_bits[75:68])};
  endproperty
  a_tcg_mag: assert property (p_tcg_mag) else $error("gain tempco magnitude wrong");

  property p_polarity;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      s_load |=> o_coeff.bridge_polarity_invert == $past(i_nvm_bits[87]);
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity flag wrong");

  property p_bridge_sample;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      1'b1 |=> o_bridge_sample == ($past(o_coeff.bridge_polarity_invert) ? ~$past(i_bridge_raw_sample) : $past(i_bridge_raw_sample));
  endproperty
  a_bridge_sample: assert property (p_bridge_sample) else $error("bridge sample wrong");

  property p_target_flags;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      s_load |=> o_coeff.second_order_target_select == $past(i_nvm_bits[99:98])
        && o_coeff.second_order_on_gain_tempco == ($past(i_nvm_bits[99:98]) == SEL_GAIN_TC);
  endproperty
  a_target_flags: assert property (p_target_flags) else $error("target flags wrong");

  property p_pamp_g24;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      s_load ##0 (i_nvm_bits[97:96] == 2'h1) |=> o_coeff.preamp_gain == PAMP_G24;
  endproperty
  a_pamp_g24: assert property (p_pamp_g24) else $error("preamp default gain wrong");

  property p_pamp_g6;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      s_load ##0 (i_nvm_bits[97:96] == 2'h0) |=> o_coeff.preamp_gain == PAMP_G6;
  endproperty
  a_pamp_g6: assert property (p_pamp_g6) else $error("preamp lowest gain wrong");

  property p_pamp_g12;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      s_load ##0 (i_nvm_bits[97:96] == 2'h2) |=> o_coeff.preamp_gain == PAMP_G12;
  endproperty
  a_pamp_g12: assert property (p_pamp_g12) else $error("preamp middle gain wrong");

  property p_hold;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      !load_now |=> $stable(o_coeff) && $stable(o_sot_prohibited);
  endproperty
  a_hold: assert property (p_hold) else $error("coefficients changed without a load");

  property p_valid_stays;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      o_coeff_valid |=> o_coeff_valid;
  endproperty
  a_valid_stays: assert property (p_valid_stays) else $error("valid dropped after load");
endmodule : ccd_decoder
`default_nettype wire

// [tb/ccd_host_model.sv]
/*
  host calibration model: keeps the store image that the host programs and
  strobes a reload after each write. assumes bench writes on the falling edge.
*/
`default_nettype none
module ccd_host_model
  import ccd_pkg::*;
(
  input wire logic i_ref_clk,                 // bench clock
  input wire logic i_rst_b,                   // async reset, active low
  input wire logic i_wr,                      // write request
  input wire logic [NV_HI:NV_LO] i_wr_bits,   // image to program
  input wire logic i_allow_bad,               // permit the prohibited target
  input wire logic i_store_ok,                // store contents are valid
  output logic [NV_HI:NV_LO] o_nvm_bits,      // programmed image
  output logic o_nvm_ready,                   // store valid level
  output logic o_nvm_update                   // reload pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  // host-side limits applied before programming
  function automatic logic [NV_HI:NV_LO] clean(input logic [NV_HI:NV_LO] b, input logic bad);
    logic [NV_HI:NV_LO] c;
    c = b;
    if (!bad && c[99:98] == 2'h3) c[99:98] = 2'h2;
    if (c[99:98] == 2'h2) c[29] = 1'b0;
    if (c[99:98] == 2'h0 && c[95] && c[94:88] > 7'h40) c[95:88] = 8'hc0;
    return c;
  endfunction : clean
  // program the store over the link, then strobe a reload
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_nvm_bits <= '0;
      o_nvm_update <= 1'b0;
      o_nvm_ready <= 1'b0;
    end else begin
      o_nvm_update <= i_wr;
      o_nvm_ready <= i_store_ok;
      if (i_wr) o_nvm_bits <= clean(i_wr_bits, i_allow_bad);
    end
  end
endmodule : ccd_host_model
`default_nettype wire

// [tb/tb.sv]
/*
  bench for the coefficient decoder: a host model programs images, a driver
  notes expected results in queues, a watcher compares them.
  assumes ccd_pkg and ccd_decoder are compiled first.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ccd_pkg::*;
  typedef struct packed {logic pro; ccd_coeff_t c;} ccd_exp_t;
  logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, allow_bad = 1'b0, store_ok = 1'b0, run = 1'b0;
  logic rdy, upd, valid, pro, loaded = 1'b0, exp_pol = 1'b0, due_s = 1'b0, due_c = 1'b0;
  logic [NV_HI:NV_LO] wr_bits = '0, nvm, b;
  logic [13:0] raw_b = '0, raw_t = '0, o_b, o_t;
  logic [95:0] r;
  ccd_coeff_t coeff;
  ccd_exp_t cq[$], e;
  logic [27:0] sq[$], es;
  int seed, miscompares = 0, n_tests = 0;
  always #4 clk = ~clk;
  ccd_host_model host (.i_ref_clk(clk), .i_rst_b(rst_b), .i_wr(wr), .i_wr_bits(wr_bits),
    .i_allow_bad(allow_bad), .i_store_ok(store_ok), .o_nvm_bits(nvm), .o_nvm_ready(rdy), .o_nvm_update(upd));
  ccd_decoder dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_nvm_bits(nvm), .i_nvm_ready(rdy), .i_nvm_update(upd),
    .i_bridge_raw_sample(raw_b), .i_temp_raw_sample(raw_t), .o_coeff(coeff), .o_coeff_valid(valid),
    .o_sot_prohibited(pro), .o_bridge_sample(o_b), .o_temp_sample(o_t));
  // expected decode of one store image
  function automatic ccd_exp_t dec(input logic [NV_HI:NV_LO] x);
    ccd_exp_t d;
    logic [11:0] t;
    logic [10:0] s;
    d = '0;
    d.pro = (x[99:98] == 2'h3);
    d.c.bridge_gain = x[29] ? {x[28:15], 3'h0} : {3'h0, x[28:15]};
    d.c.bridge_offset = x[43:30];
    d.c.temp_gain = x[51:44];
    d.c.temp_offset = x[59:52];
    d.c.temp_reference_raw = x[67:60];
    d.c.gain_tempco = x[86] ? -$signed({1'b0, x[75:68]}) : $signed({1'b0, x[75:68]});
    t = x[85] ? {1'b0, x[83:76], 3'h0} : {4'h0, x[83:76]};
    d.c.offset_tempco = x[84] ? -t : t;
    s = (x[85] && x[99:98] == 2'h2) ? {1'b0, x[94:88], 3'h0} : {4'h0, x[94:88]};
    d.c.second_order = x[95] ? -s : s;
    d.c.second_order_target_select = x[99:98];
    d.c.second_order_on_bridge = (x[99:98] == 2'h0);
    d.c.second_order_on_gain_tempco = (x[99:98] == 2'h1);
    d.c.second_order_on_offset_tempco = (x[99:98] == 2'h2);
    d.c.bridge_polarity_invert = x[87];
    case (x[97:96])
      2'h0: d.c.preamp_gain = 6'h06;
      2'h1: d.c.preamp_gain = 6'h18;
      2'h2: d.c.preamp_gain = 6'h0c;
      default: d.c.preamp_gain = 6'h30;
    endcase
    return d;
  endfunction : dec
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("MISMATCH at %0t: %s", $time, m);
    end
  endtask : chk
  // one write per falling edge; after the first load, the image is noted once the store holds it
  task automatic write(input logic [NV_HI:NV_LO] x);
    wr = 1'b1;
    wr_bits = x;
    @(negedge clk);
    if (loaded) cq.push_back(dec(nvm));
  endtask : write
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  // raw sample driver and its notes
  always @(negedge clk) begin
    if (run) begin
      raw_b = 14'($random(seed));
      raw_t = 14'($random(seed));
      sq.push_back({exp_pol ? ~raw_b : raw_b, raw_t & 14'h3ffc});
    end
  end
  // watcher: find which results are due at this edge
  always @(posedge clk) begin
    due_s = (sq.size() > 0);
    due_c = 1'b0;
    if (rst_b && cq.size() > 0 && (loaded ? upd : rdy)) begin
      due_c = 1'b1;
      loaded = 1'b1;
      exp_pol = cq[0].c.bridge_polarity_invert;
    end
  end
  // watcher: compare the oldest notes with the settled outputs
  always @(negedge clk) begin
    if (due_s) begin
      es = sq.pop_front();
      chk({o_b, o_t} === es, "raw sample");
    end
    if (due_c) begin
      e = cq.pop_front();
      chk(coeff === e.c, "coefficients");
      chk(pro === e.pro && valid === 1'b1, "target flag or valid");
    end
  end
  initial begin
    #20us;
    miscompares++;
    close_out();
  end
  initial begin
    seed = 92;
    repeat (20) @(negedge clk);
    chk(coeff === '0 && valid === 1'b0, "reset outputs");
    rst_b = 1'b1;
    run = 1'b1;
    $display("test reset done");
    write(85'h0);
    wr = 1'b0;
    repeat (3) @(negedge clk);
    chk(valid === 1'b0, "reload before first load");
    store_ok = 1'b1;
    @(negedge clk);
    cq.push_back(dec(nvm));
    repeat (3) @(negedge clk);
    chk(valid === 1'b1 && cq.size() == 0, "first load");
    $display("test first load done");
    for (int i = 0; i < 16; i++) begin
      r = {$random(seed), $random(seed), $random(seed)};
      b = r[84:0];
      {b[99:98], b[97:96]} = i[3:0];
      {b[87], b[86], b[85], b[84], b[29]} = {i[0], i[1], i[3], ~i[0], i[2]};
      allow_bad = (i[3:2] == 2'h3);
      write(b);
    end
    wr = 1'b0;
    allow_bad = 1'b0;
    $display("test back to back codes done");
    for (int i = 0; i < 40; i++) begin
      r = {$random(seed), $random(seed), $random(seed)};
      write(r[84:0]);
      if (i % 3 != 0) begin
        wr = 1'b0; // back-to-back writes keep the request up
        repeat (i % 3) @(negedge clk);
      end
    end
    wr = 1'b0;
    repeat (4) @(negedge clk);
    chk(cq.size() == 0, "all loads seen");
    $display("test random images done");
    close_out();
  end
endmodule : tb
`default_nettype wire
